// ### rtl/cis_core.sv
`timescale 1ns/100ps
`include "cis_defs.svh"
// Overview of operation
// - reset or stack reset instruction loads FF
// - push post-decrements, pull pre-increments pointer
// - stack address forced into 00C0..00FF
// - 64-byte stack wraps silently
// - call moves pointer down two bytes without writing them, interrupt pushes five
// - 8-bit accumulator holds operands and results
// - 8-bit index register for indexed addressing
// - 16-bit program counter holds next fetch
// - five-bit flags; half carry from bit 3
// - negative and zero flags follow result
// - carry from ALU, bit tests, shifts
// - mask blocks maskable requests, keeps them latched
// - entry stacks registers then sets mask
// - return restores stack and resumes
// - requests evaluated only at instruction boundaries
// - take only if unmasked and enabled
// - priority reset, external, timer, SCI, SPI
// - fixed vector addresses, high byte first
// - software trap ignores mask, ordered by fetch
// - falling edge synchronised then latched
// - pulled-up port B pins add request sources
// - edge-only or level-and-edge selectable
module cis_core (
    input  wire logic                 ref_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 irq_n_i,
    input  wire logic [7:0]           port_b_i,
    input  wire logic [7:0]           port_b_pullup_en_i,
    input  wire logic                 edge_only_i,
    input  wire cis_pkg::cis_tmr_t    tmr_i,
    input  wire cis_pkg::cis_sci_t    sci_i,
    input  wire cis_pkg::cis_spi_t    spi_i,
    input  wire logic                 boundary_i,
    input  wire logic                 software_trap_instr_i,
    input  wire logic                 interrupt_return_instr_i,
    input  wire logic                 stack_pointer_reset_instr_i,
    input  wire logic                 call_instr_i,
    input  wire logic                 ret_instr_i,
    input  wire logic [15:0]          call_target_i,
    input  wire logic                 pc_inc_i,
    input  wire logic                 pc_load_i,
    input  wire logic [15:0]          pc_value_i,
    input  wire logic                 acc_we_i,
    input  wire logic [7:0]           acc_d_i,
    input  wire logic                 idx_we_i,
    input  wire logic [7:0]           idx_d_i,
    input  wire cis_pkg::cis_ccr_upd_t ccr_upd_i,
    input  wire logic [7:0]           mem_rdata_i,
    output logic [15:0]               mem_addr_o,
    output logic [7:0]                mem_wdata_o,
    output logic                      mem_we_o,
    output logic                      mem_re_o,
    output logic                      busy_o,
    output logic [7:0]                acc_o,
    output logic [7:0]                idx_o,
    output logic [15:0]               pc_o,
    output logic [7:0]                sp_o,
    output logic [4:0]                condition_code_register_o,
    output logic                      branch_if_request_low_o,
    output logic                      branch_if_request_high_o,
    output cis_pkg::cis_src_t         taken_src_o
);
    localparam int NPIN = 9;

    cis_pkg::cis_state_t state_q;
    cis_pkg::cis_src_t   src_q;
    logic [2:0]          cnt_q;
    logic [7:0]          acc_q;
    logic [7:0]          idx_q;
    logic [15:0]         pc_q;
    logic [7:0]          sp_q;
    logic [4:0]          ccr_q;
    logic [7:0]          vec_hi_q;
    logic                rst_vec_q;
    logic                swi_arm_q;

    logic [NPIN-1:0] req_n_w;
    logic [NPIN-1:0] lvl_w;
    logic [NPIN-1:0] pend_w;
    logic [NPIN-1:0] src_en_w;
    logic            ext_clr_w;

    assign req_n_w  = {port_b_i, irq_n_i};
    assign src_en_w = {port_b_pullup_en_i, 1'b1};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_ext
            cis_ext_req u_req (
                .ref_clk_i   (ref_clk_i),
                .sys_rst_i   (sys_rst_i),
                .req_n_i     (req_n_w[g]),
                .edge_only_i (edge_only_i),
                .clear_i     (ext_clr_w),
                .pin_level_o (lvl_w[g]),
                .pending_o   (pend_w[g])
            );
        end
    endgenerate

    // pin-level branch tests see the IRQ pin and every enabled port B pin
    wire req_low_w = |(~lvl_w & src_en_w);
    assign branch_if_request_low_o  = req_low_w;
    assign branch_if_request_high_o = ~req_low_w;

    wire ext_pend_w = |(pend_w & src_en_w);
    wire tmr_pend_w = (tmr_i.capture_event_flag & tmr_i.capture_irq_enable)
                    | (tmr_i.compare_match_flag & tmr_i.compare_irq_enable)
                    | (tmr_i.counter_overflow_flag & tmr_i.overflow_irq_enable);
    wire sci_pend_w = ((sci_i.tx_buffer_empty_flag | sci_i.tx_complete_flag)
                        & sci_i.tx_irq_enable)
                    | ((sci_i.rx_full_flag | sci_i.overrun_flag) & sci_i.rx_irq_enable)
                    | (sci_i.idle_flag & sci_i.idle_irq_enable);
    wire spi_pend_w = (spi_i.transfer_done_flag | spi_i.mode_fault_flag)
                    & spi_i.serial_periph_irq_enable;
    wire mask_w     = ccr_q[`CIS_CCR_I];
    wire any_hw_w   = ~mask_w & (ext_pend_w | tmr_pend_w | sci_pend_w | spi_pend_w);

    // hardware source chosen in fixed priority order
    cis_pkg::cis_src_t hw_src_w;
    assign hw_src_w = ext_pend_w ? cis_pkg::CIS_SRC_EXT :
                      tmr_pend_w ? cis_pkg::CIS_SRC_TMR :
                      sci_pend_w ? cis_pkg::CIS_SRC_SCI :
                                   cis_pkg::CIS_SRC_SPI;

    // a trap fetched at a boundary that takes a hardware entry runs after that one entry; once armed,
    // it is taken at the next boundary ahead of later arrivals
    wire take_hw_w  = (state_q == cis_pkg::CIS_ST_RUN) & boundary_i & ~swi_arm_q
                    & any_hw_w;
    wire take_swi_w = (state_q == cis_pkg::CIS_ST_RUN) & boundary_i & ~take_hw_w
                    & (swi_arm_q | software_trap_instr_i);
    wire do_rti_w   = (state_q == cis_pkg::CIS_ST_RUN) & boundary_i & ~take_hw_w
                    & ~take_swi_w & interrupt_return_instr_i;
    wire run_w      = (state_q == cis_pkg::CIS_ST_RUN) & ~take_hw_w & ~take_swi_w
                    & ~do_rti_w;
    assign ext_clr_w = take_hw_w & (hw_src_w == cis_pkg::CIS_SRC_EXT);

    // stack frame: PCL, PCH, X, A, CONDITION_CODE_REGISTER pushed in that order
    logic [7:0] push_b_w;
    always_comb begin
        unique case (cnt_q)
            3'h0:    push_b_w = pc_q[7:0];
            3'h1:    push_b_w = pc_q[15:8];
            3'h2:    push_b_w = idx_q;
            3'h3:    push_b_w = acc_q;
            default: push_b_w = {3'h7, ccr_q};
        endcase
    end

    wire push_w = (state_q == cis_pkg::CIS_ST_PUSH);
    wire pull_w = (state_q == cis_pkg::CIS_ST_PULL);
    wire [7:0] sp_inc_w = {2'h3, sp_q[5:0] + 6'h01};
    wire [7:0] sp_dec_w = {2'h3, sp_q[5:0] - 6'h01};
    wire [7:0] sp_addr_w = pull_w ? sp_inc_w : sp_q;

    logic [15:0] vec_w;
    always_comb begin
        unique case (src_q)
            cis_pkg::CIS_SRC_RESET: vec_w = `CIS_VEC_RESET;
            cis_pkg::CIS_SRC_SWI:   vec_w = `CIS_VEC_SWI;
            cis_pkg::CIS_SRC_EXT:   vec_w = `CIS_VEC_EXT;
            cis_pkg::CIS_SRC_TMR:   vec_w = `CIS_VEC_TMR;
            cis_pkg::CIS_SRC_SCI:   vec_w = `CIS_VEC_SCI;
            default:                vec_w = `CIS_VEC_SPI;
        endcase
    end

    wire vec_w_lo_w = (state_q == cis_pkg::CIS_ST_VECLO);
    wire [15:0] vec_addr_w = vec_w_lo_w ? vec_w + 16'h0001 : vec_w;
    wire        vec_w_act  = (state_q == cis_pkg::CIS_ST_VECHI) | vec_w_lo_w;
    wire [15:0] stk_addr_w = {`CIS_SP_HIGH, sp_addr_w[5:0]};

    assign mem_addr_o  = vec_w_act ? vec_addr_w : stk_addr_w;
    assign mem_wdata_o = push_b_w;
    assign mem_we_o    = push_w;
    assign mem_re_o    = vec_w_act | pull_w;
    assign busy_o      = (state_q != cis_pkg::CIS_ST_RUN) | rst_vec_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q   <= cis_pkg::CIS_ST_RUN;
            src_q     <= cis_pkg::CIS_SRC_RESET;
            cnt_q     <= 3'h0;
            sp_q      <= `CIS_SP_RESET;
            rst_vec_q <= 1'b1;
            swi_arm_q <= 1'b0;
        end else begin
            if (rst_vec_q) begin
                rst_vec_q <= 1'b0;
                state_q   <= cis_pkg::CIS_ST_VECHI;
            end else begin
                unique case (state_q)
                    cis_pkg::CIS_ST_RUN: begin
                        if (software_trap_instr_i & take_hw_w)
                            swi_arm_q <= 1'b1;
                        if (take_hw_w | take_swi_w) begin
                            state_q   <= cis_pkg::CIS_ST_PUSH;
                            src_q     <= take_hw_w ? hw_src_w : cis_pkg::CIS_SRC_SWI;
                            cnt_q     <= 3'h0;
                            if (take_swi_w)
                                swi_arm_q <= 1'b0;
                        end else if (do_rti_w) begin
                            state_q <= cis_pkg::CIS_ST_PULL;
                            cnt_q   <= 3'h0;
                        end else if (stack_pointer_reset_instr_i) begin
                            sp_q <= `CIS_SP_RESET;
                        end else if (call_instr_i) begin
                            sp_q <= {2'h3, sp_q[5:0] - 6'h02};
                        end else if (ret_instr_i) begin
                            sp_q <= {2'h3, sp_q[5:0] + 6'h02};
                        end
                    end
                    cis_pkg::CIS_ST_PUSH: begin
                        sp_q  <= sp_dec_w;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h4)
                            state_q <= cis_pkg::CIS_ST_VECHI;
                    end
                    cis_pkg::CIS_ST_VECHI: state_q <= cis_pkg::CIS_ST_VECLO;
                    cis_pkg::CIS_ST_VECLO: state_q <= cis_pkg::CIS_ST_RUN;
                    cis_pkg::CIS_ST_PULL: begin
                        sp_q  <= sp_inc_w;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h4)
                            state_q <= cis_pkg::CIS_ST_RUN;
                    end
                    default: state_q <= cis_pkg::CIS_ST_RUN;
                endcase
            end
        end
    end

    // pull order: CONDITION_CODE_REGISTER, A, X, PCH, PCL
    wire pul_ccr_w = pull_w & (cnt_q == 3'h0);
    wire pul_acc_w = pull_w & (cnt_q == 3'h1);
    wire pul_idx_w = pull_w & (cnt_q == 3'h2);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            acc_q <= 8'h00;
            idx_q <= 8'h00;
        end else begin
            if (pul_acc_w)
                acc_q <= mem_rdata_i;
            else if (acc_we_i)
                acc_q <= acc_d_i;
            if (pul_idx_w)
                idx_q <= mem_rdata_i;
            else if (idx_we_i)
                idx_q <= idx_d_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pc_q     <= `CIS_PC_RESET;
            vec_hi_q <= 8'h00;
        end else if (state_q == cis_pkg::CIS_ST_VECHI) begin
            vec_hi_q <= mem_rdata_i;
        end else if (vec_w_lo_w) begin
            pc_q <= {vec_hi_q, mem_rdata_i};
        end else if (pull_w & (cnt_q == 3'h3)) begin
            pc_q[15:8] <= mem_rdata_i;
        end else if (pull_w & (cnt_q == 3'h4)) begin
            pc_q[7:0] <= mem_rdata_i;
        end else if (run_w & call_instr_i) begin
            pc_q <= call_target_i;
        end else if (run_w & pc_load_i) begin
            pc_q <= pc_value_i;
        end else if (run_w & pc_inc_i) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ccr_q <= `CIS_CCR_RESET;
        end else if (push_w & (cnt_q == 3'h4)) begin
            ccr_q[`CIS_CCR_I] <= 1'b1;
        end else if (pul_ccr_w) begin
            ccr_q <= mem_rdata_i[4:0];
        end else if (run_w & ccr_upd_i.valid) begin
            if (ccr_upd_i.h_upd)
                ccr_q[`CIS_CCR_H] <= ccr_upd_i.flags[`CIS_CCR_H];
            if (ccr_upd_i.nz_upd) begin
                ccr_q[`CIS_CCR_N] <= ccr_upd_i.flags[`CIS_CCR_N];
                ccr_q[`CIS_CCR_Z] <= ccr_upd_i.flags[`CIS_CCR_Z];
            end
            if (ccr_upd_i.c_upd)
                ccr_q[`CIS_CCR_C] <= ccr_upd_i.flags[`CIS_CCR_C];
            if (ccr_upd_i.mask_set)
                ccr_q[`CIS_CCR_I] <= 1'b1;
            else if (ccr_upd_i.mask_clr)
                ccr_q[`CIS_CCR_I] <= 1'b0;
        end
    end

    assign acc_o = acc_q;
    assign idx_o = idx_q;
    assign pc_o  = pc_q;
    assign sp_o  = sp_q;
    assign condition_code_register_o = ccr_q;
    assign taken_src_o = src_q;

    AST_SP_RANGE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        sp_q[7:6] == 2'h3) else $error("stack pointer left range");
    AST_SPRST: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        run_w & stack_pointer_reset_instr_i |=> sp_q == 8'hFF)
        else $error("stack reset missed");
    AST_PUSH5: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(push_w) |-> push_w [*5] ##1 state_q == cis_pkg::CIS_ST_VECHI)
        else $error("entry not five pushes");
    AST_MASKSET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        state_q == cis_pkg::CIS_ST_VECHI |-> ccr_q[`CIS_CCR_I])
        else $error("mask not set on entry");
    // an entry begun while masked may only be the software trap
    AST_MASKED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(push_w) & $past(mask_w) |-> src_q == cis_pkg::CIS_SRC_SWI)
        else $error("masked request taken");
    AST_BOUNDARY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(push_w) |-> $past(boundary_i))
        else $error("entry off boundary");
    AST_PRIO: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take_hw_w & ext_pend_w |=> src_q == cis_pkg::CIS_SRC_EXT)
        else $error("external not first");
    AST_VEC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        state_q == cis_pkg::CIS_ST_VECHI |-> mem_addr_o[15:4] == 12'h3FF & ~mem_addr_o[0])
        else $error("bad vector address");
    AST_SP_DEC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        push_w |=> sp_q[5:0] == $past(sp_q[5:0]) - 6'h01)
        else $error("push did not decrement");
endmodule

// ### inc/cis_defs.svh
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
`define CIS_SP_RESET      8'hFF
`define CIS_SP_HIGH       10'h003
`define CIS_VEC_RESET     16'h3FFE
`define CIS_VEC_SWI       16'h3FFC
`define CIS_VEC_EXT       16'h3FFA
`define CIS_VEC_TMR       16'h3FF8
`define CIS_VEC_SCI       16'h3FF6
`define CIS_VEC_SPI       16'h3FF4
`define CIS_PC_RESET      16'h0000
`define CIS_CCR_RESET     5'h08
`define CIS_CCR_H         4
`define CIS_CCR_I         3
`define CIS_CCR_N         2
`define CIS_CCR_Z         1
`define CIS_CCR_C         0
`define CIS_STACK_SIZE    64
`endif

// ### inc/cis_pkg.sv
package cis_pkg;
    typedef enum logic [2:0] {
        CIS_SRC_NONE  = 3'h0,
        CIS_SRC_RESET = 3'h1,
        CIS_SRC_EXT   = 3'h2,
        CIS_SRC_TMR   = 3'h3,
        CIS_SRC_SCI   = 3'h4,
        CIS_SRC_SPI   = 3'h5,
        CIS_SRC_SWI   = 3'h6
    } cis_src_t;

    typedef enum logic [2:0] {
        CIS_ST_RUN    = 3'h0,
        CIS_ST_PUSH   = 3'h1,
        CIS_ST_VECHI  = 3'h2,
        CIS_ST_VECLO  = 3'h3,
        CIS_ST_PULL   = 3'h4
    } cis_state_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] flags;
        logic       h_upd;
        logic       c_upd;
        logic       nz_upd;
        logic       mask_set;
        logic       mask_clr;
    } cis_ccr_upd_t;

    typedef struct packed {
        logic       capture_event_flag;
        logic       compare_match_flag;
        logic       counter_overflow_flag;
        logic       capture_irq_enable;
        logic       compare_irq_enable;
        logic       overflow_irq_enable;
    } cis_tmr_t;

    typedef struct packed {
        logic       tx_buffer_empty_flag;
        logic       tx_complete_flag;
        logic       rx_full_flag;
        logic       overrun_flag;
        logic       idle_flag;
        logic       tx_irq_enable;
        logic       rx_irq_enable;
        logic       idle_irq_enable;
    } cis_sci_t;

    typedef struct packed {
        logic       transfer_done_flag;
        logic       mode_fault_flag;
        logic       serial_periph_irq_enable;
    } cis_spi_t;
endpackage

// ### rtl/cis_ext_req.sv
`timescale 1ns/100ps
// one external request source: edge capture plus optional level sense
module cis_ext_req (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic req_n_i,
    input  wire logic edge_only_i,
    input  wire logic clear_i,
    output logic      pin_level_o,
    output logic      pending_o
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic latch_q;
    wire  fall_w = prev_q & ~sync2_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
            latch_q <= 1'b0;
        end else begin
            sync1_q <= req_n_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            // new edge in the clear cycle survives
            latch_q <= fall_w | (latch_q & ~clear_i);
        end
    end

    assign pin_level_o = sync2_q;
    assign pending_o   = latch_q | (~edge_only_i & ~sync2_q);
endmodule

// ### testbench/cis_src_model.sv
`timescale 1ns/100ps
// far side: peripheral flags, request pin and a byte memory holding vectors and stack
module cis_src_model (
    input  wire logic         ref_clk_i,
    input  wire logic [3:0]   src_i,
    input  wire logic         en_i,
    input  wire logic [15:0]  mem_addr_i,
    input  wire logic [7:0]   mem_wdata_i,
    input  wire logic         mem_we_i,
    input  wire logic         mem_re_i,
    output logic              irq_n_o,
    output cis_pkg::cis_tmr_t tmr_o,
    output cis_pkg::cis_sci_t sci_o,
    output cis_pkg::cis_spi_t spi_o,
    output logic [7:0]        mem_rdata_o
);
    logic [7:0] stk_q [0:255];
    logic [7:0] flip_q = 8'h00;
    logic [7:0] rd_w;
    assign irq_n_o = ~src_i[0];
    // vector bytes are a fixed scramble of the low address so every vector differs
    assign rd_w = (mem_addr_i[15:8] == 8'h3F) ? (mem_addr_i[7:0] ^ 8'h5A)
                                              : stk_q[mem_addr_i[7:0]];
    // idle read bus changes every cycle so a stale sample cannot pass
    assign mem_rdata_o = mem_re_i ? rd_w : flip_q;
    always_comb begin
        tmr_o = '0;
        sci_o = '0;
        spi_o = '0;
        tmr_o.capture_event_flag = src_i[1];
        tmr_o.capture_irq_enable = en_i;
        sci_o.rx_full_flag = src_i[2];
        sci_o.rx_irq_enable = en_i;
        spi_o.transfer_done_flag = src_i[3];
        spi_o.serial_periph_irq_enable = en_i;
    end
    always_ff @(posedge ref_clk_i) begin
        flip_q <= ~flip_q;
        if (mem_we_i) begin
            stk_q[mem_addr_i[7:0]] <= mem_wdata_i;
        end
    end
endmodule

// ### testbench/cpu_interrupt_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "cis_defs.svh"
module cpu_interrupt_sequencer_tb_top;
    logic ref_clk, sys_rst, boundary, trap, interrupt_return_instr, sprst, call, ret, acc_we, idx_we, pc_load;
    logic edge_only, en, pc_inc, hold_irq;
    logic [3:0]  src;
    logic [7:0]  port_b, pb_en, acc_d, idx_d, rdata, wdata, acc_o, idx_o, sp_o;
    logic [15:0] call_target, pc_value, mem_addr, pc_o;
    logic [4:0]  ccr_o, fl;
    logic        irq_n, we, re, busy, branch_if_request_low, branch_if_request_high;
    cis_pkg::cis_ccr_upd_t ccr_upd;
    cis_pkg::cis_tmr_t     tmr;
    cis_pkg::cis_sci_t     sci;
    cis_pkg::cis_spi_t     spi;
    cis_pkg::cis_src_t     tsrc;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          seed = 32'h0122;
    cis_core cis_core_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .irq_n_i(irq_n),
        .port_b_i(port_b), .port_b_pullup_en_i(pb_en), .edge_only_i(edge_only), .tmr_i(tmr),
        .sci_i(sci), .spi_i(spi), .boundary_i(boundary), .software_trap_instr_i(trap),
        .interrupt_return_instr_i(interrupt_return_instr), .stack_pointer_reset_instr_i(sprst),
        .call_instr_i(call), .ret_instr_i(ret), .call_target_i(call_target), .pc_inc_i(pc_inc),
        .pc_load_i(pc_load), .pc_value_i(pc_value), .acc_we_i(acc_we), .acc_d_i(acc_d),
        .idx_we_i(idx_we), .idx_d_i(idx_d), .ccr_upd_i(ccr_upd), .mem_rdata_i(rdata),
        .mem_addr_o(mem_addr), .mem_wdata_o(wdata), .mem_we_o(we), .mem_re_o(re),
        .busy_o(busy), .acc_o(acc_o), .idx_o(idx_o), .pc_o(pc_o), .sp_o(sp_o),
        .condition_code_register_o(ccr_o), .branch_if_request_low_o(branch_if_request_low),
        .branch_if_request_high_o(branch_if_request_high), .taken_src_o(tsrc));
    cis_src_model cis_src_model_i (.ref_clk_i(ref_clk), .src_i(src), .en_i(en),
        .mem_addr_i(mem_addr), .mem_wdata_i(wdata), .mem_we_i(we), .mem_re_i(re),
        .irq_n_o(irq_n), .tmr_o(tmr), .sci_o(sci), .spi_o(spi), .mem_rdata_o(rdata));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] vec(input logic [15:0] a);
        return {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 30 && busy !== 1'b0; k++) tick(1);
        if (busy !== 1'b0) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic mask(input logic v);
        @(posedge ref_clk);
        ccr_upd <= {1'b1, 5'h00, 3'h0, v, ~v};
        @(posedge ref_clk);
        ccr_upd <= '0;
        tick(1);
    endtask
    // take one entry, check the stacking walk, then return and check restoration
    task automatic service(input logic t, input logic [15:0] va, input cis_pkg::cis_src_t es);
        logic [7:0]  sp0, a0;
        logic [15:0] pc0;
        logic [4:0]  c0;
        int          nw;
        sp0 = sp_o;
        a0 = acc_o;
        pc0 = pc_o;
        c0 = ccr_o;
        nw = 0;
        @(posedge ref_clk);
        boundary <= 1'b1;
        trap <= t;
        @(posedge ref_clk);
        boundary <= 1'b0;
        trap <= 1'b0;
        #1;
        for (int k = 0; k < 20 && busy === 1'b1; k++) begin
            if (we === 1'b1) begin
                chk(mem_addr, {10'h003, sp0[5:0] - 6'(nw)});
                nw++;
            end
            tick(1);
        end
        chk(16'(nw), 16'h0005);
        chk(sp_o, {2'h3, sp0[5:0] - 6'h05});
        chk(ccr_o[`CIS_CCR_I], 1'b1);
        chk(pc_o, vec(va));
        chk(tsrc, es);
        // hold_irq keeps the pin low so a later entry can only come from level sense
        src <= {3'h0, hold_irq};
        port_b <= 8'hFF;
        @(posedge ref_clk);
        boundary <= 1'b1;
        interrupt_return_instr <= 1'b1;
        @(posedge ref_clk);
        boundary <= 1'b0;
        interrupt_return_instr <= 1'b0;
        tick(1);
        wait_idle();
        chk({sp_o, acc_o}, {sp0, a0});
        chk(pc_o, pc0);
        chk(ccr_o, c0);
        $display("test entry done src %0d", es);
    endtask
    initial begin
        {boundary, trap, interrupt_return_instr, sprst, call, ret, acc_we, idx_we, pc_load, pc_inc} = '0;
        {src, acc_d, idx_d, call_target, pc_value, pb_en} = '0;
        port_b = 8'hFF;
        edge_only = 1'b1;
        en = 1'b1;
        hold_irq = 1'b0;
        ccr_upd = '0;
        sys_rst = 1'b1;
        tick(8);
        sys_rst <= 1'b0;
        tick(2);
        wait_idle();
        chk(pc_o, vec(`CIS_VEC_RESET));
        chk(sp_o, 8'hFF);
        chk(ccr_o[`CIS_CCR_I], 1'b1);
        chk(tsrc, cis_pkg::CIS_SRC_RESET);
        chk({branch_if_request_low, branch_if_request_high}, 2'h1);
        for (int i = 0; i < 8; i++) begin
            fl = 5'($random(seed));
            @(posedge ref_clk);
            {acc_we, idx_we, pc_load} <= 3'h7;
            acc_d <= 8'($random(seed));
            idx_d <= 8'($random(seed));
            pc_value <= 16'($random(seed));
            ccr_upd <= {1'b1, fl, 3'h7, 2'h0};
            @(posedge ref_clk);
            {acc_we, idx_we, pc_load} <= 3'h0;
            ccr_upd <= '0;
            tick(1);
            chk(acc_o, acc_d);
            chk(idx_o, idx_d);
            chk(pc_o, pc_value);
            chk(ccr_o[`CIS_CCR_H], fl[4]);
            chk(ccr_o[2:1], fl[2:1]);
            chk(ccr_o[`CIS_CCR_C], fl[0]);
        end
        @(posedge ref_clk);
        pc_inc <= 1'b1;
        @(posedge ref_clk);
        pc_inc <= 1'b0;
        tick(1);
        chk(pc_o, pc_value + 16'h0001);
        $display("test registers done");
        src <= 4'h2;
        tick(3);
        @(posedge ref_clk);
        boundary <= 1'b1;
        @(posedge ref_clk);
        boundary <= 1'b0;
        tick(2);
        chk(busy, 1'b0);
        en <= 1'b0;
        mask(1'b0);
        @(posedge ref_clk);
        boundary <= 1'b1;
        @(posedge ref_clk);
        boundary <= 1'b0;
        tick(2);
        chk(busy, 1'b0);
        en <= 1'b1;
        tick(3);
        chk(busy, 1'b0);
        service(1'b0, `CIS_VEC_TMR, cis_pkg::CIS_SRC_TMR);
        // all four together, then drop the winner each round
        for (int i = 0; i < 4; i++) begin
            src <= 4'hF << i;
            tick(4);
            service(1'b0, `CIS_VEC_EXT - 16'(2 * i), cis_pkg::cis_src_t'(3'h2 + 3'(i)));
        end
        pb_en <= 8'h10;
        port_b <= 8'hEF;
        tick(4);
        chk(branch_if_request_low, 1'b1);
        chk(branch_if_request_high, 1'b0);
        service(1'b0, `CIS_VEC_EXT, cis_pkg::CIS_SRC_EXT);
        edge_only <= 1'b0;
        hold_irq = 1'b1;
        src <= 4'h1;
        tick(4);
        service(1'b0, `CIS_VEC_EXT, cis_pkg::CIS_SRC_EXT);
        hold_irq = 1'b0;
        // pin still low with the latch cleared: only level sense can enter again
        service(1'b0, `CIS_VEC_EXT, cis_pkg::CIS_SRC_EXT);
        mask(1'b1);
        service(1'b1, `CIS_VEC_SWI, cis_pkg::CIS_SRC_SWI);
        @(posedge ref_clk);
        call <= 1'b1;
        @(posedge ref_clk);
        call <= 1'b0;
        tick(1);
        chk(sp_o, 8'hFD);
        @(posedge ref_clk);
        sprst <= 1'b1;
        @(posedge ref_clk);
        sprst <= 1'b0;
        tick(1);
        chk(sp_o, 8'hFF);
        for (int i = 0; i < 32; i++) begin
            @(posedge ref_clk);
            call <= 1'b1;
            call_target <= 16'($random(seed));
            @(posedge ref_clk);
            call <= 1'b0;
            tick(1);
            chk(pc_o, call_target);
        end
        chk(sp_o, 8'hFF);
        @(posedge ref_clk);
        ret <= 1'b1;
        @(posedge ref_clk);
        ret <= 1'b0;
        tick(1);
        chk(sp_o, 8'hC1);
        $display("test stack done");
        give_verdict();
    end
endmodule
